//--- src/pfc_top.v
// Summary of operation
// - Processor-found flag reflects whether any PECI-capable processor was detected.
// - Retry-suppress bit set stops retry bit after bad completion codes.
// - Rate field selects CPU poll rate: 1, 2, 5 or 10 per second.
// - CPU write transactions issue only while the write-permit bit is set.
// - Each of three PWM outputs is clamped to its own maximum duty register.
// - Above the start temperature fans run at minimum duty then follow slope.
// - Span field selects ramp width: 2 C up to 80 C, default 32 C.
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_top #(
   parameter [25:0] POLL_CYC_RATE0 = `PFC_POLL_CYC_RATE0,
   parameter [25:0] POLL_CYC_RATE1 = `PFC_POLL_CYC_RATE1,
   parameter [25:0] POLL_CYC_RATE2 = `PFC_POLL_CYC_RATE2,
   parameter [25:0] POLL_CYC_RATE3 = `PFC_POLL_CYC_RATE3
) (
   // Clock and reset
   input  wire        core_clk_in,
   input  wire        resetn_in,
   // Register port from the serial slave
   input  wire [7:0]  reg_addr_in,
   input  wire        reg_wr_in,
   input  wire [7:0]  reg_wdata_in,
   input  wire        reg_rd_in,
   output reg  [7:0]  reg_rdata_out,
   // PECI engine status
   input  wire        detect_done_in,
   input  wire        processor_found_in,
   input  wire        bad_completion_in,
   input  wire        good_completion_in,
   input  wire        cpu_write_req_in,
   input  wire        temp_valid_in,
   input  wire [7:0]  temp_in,
   // PECI engine control
   output reg         poll_req_out,
   output reg         retry_bit_out,
   output reg         cpu_write_go_out,
   // Fan control
   input  wire [23:0] min_duty_in,
   output reg  [23:0] duty_out
);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg  [7:0]  config_one_q;
   reg  [7:0]  config_three_q;
   reg  [23:0] max_duty_q;
   reg  [7:0]  start_temp_q;
   reg  [7:0]  span_q;
   reg  [7:0]  temp_q;
   reg         retry_pend_q;
   reg  [25:0] poll_cnt_q;
   reg  [7:0]  rdata_d;
   reg  [7:0]  config_three_d;
   reg         retry_pend_d;
   reg  [25:0] poll_limit;
   wire [23:0] ramp_duty;
   wire [1:0]  rate_code = config_three_q[`PFC_RATE_MSB:`PFC_RATE_LSB];

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         config_one_q   <= `PFC_RST_CONFIG_ONE;
         config_three_q <= `PFC_RST_CONFIG_THREE;
         max_duty_q     <= {3{`PFC_RST_MAX_DUTY}};
         start_temp_q   <= `PFC_RST_RAMP_START_TEMP;
         span_q         <= `PFC_RST_RAMP_SPAN;
      end else begin
         if (reg_wr_in) begin
            case (reg_addr_in)
               `PFC_OFS_PECI_CONFIG_ONE: begin
                  config_one_q <= reg_wdata_in & `PFC_MASK_CONFIG_ONE;
               end
               `PFC_OFS_PWM1_MAX_DUTY: begin
                  max_duty_q[7:0] <= reg_wdata_in;
               end
               `PFC_OFS_PWM2_MAX_DUTY: begin
                  max_duty_q[15:8] <= reg_wdata_in;
               end
               `PFC_OFS_PWM3_MAX_DUTY: begin
                  max_duty_q[23:16] <= reg_wdata_in;
               end
               `PFC_OFS_RAMP_START_TEMP: begin
                  start_temp_q <= reg_wdata_in;
               end
               `PFC_OFS_RAMP_SPAN: begin
                  span_q <= reg_wdata_in & `PFC_MASK_RAMP_SPAN;
               end
               default: begin
               end
            endcase
         end
         config_three_q <= config_three_d;
      end
   end

   // ----------------------------------------------------------------------
   // Control register: detection result wins over a same-cycle write
   // ----------------------------------------------------------------------
   always @* begin
      config_three_d = config_three_q;
      if (reg_wr_in && (reg_addr_in == `PFC_OFS_PECI_CONFIG_THREE)) begin
         config_three_d = reg_wdata_in & `PFC_MASK_CONFIG_THREE;
      end
      if (detect_done_in) begin
         config_three_d[`PFC_BIT_PROCESSOR_FOUND] = processor_found_in;
      end
   end

   // ----------------------------------------------------------------------
   // Retry pending: a bad completion code wins over a good one
   // ----------------------------------------------------------------------
   always @* begin
      retry_pend_d = retry_pend_q;
      if (bad_completion_in) begin
         retry_pend_d = 1'b1;
      end else if (good_completion_in) begin
         retry_pend_d = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   always @* begin
      case (reg_addr_in)
         `PFC_OFS_PECI_CONFIG_ONE:   rdata_d = config_one_q;
         `PFC_OFS_PECI_CONFIG_THREE: rdata_d = config_three_q;
         `PFC_OFS_PWM1_MAX_DUTY:     rdata_d = max_duty_q[7:0];
         `PFC_OFS_PWM2_MAX_DUTY:     rdata_d = max_duty_q[15:8];
         `PFC_OFS_PWM3_MAX_DUTY:     rdata_d = max_duty_q[23:16];
         `PFC_OFS_RAMP_START_TEMP:   rdata_d = start_temp_q;
         `PFC_OFS_RAMP_SPAN:         rdata_d = span_q;
         default:                    rdata_d = `PFC_READ_UNMAPPED;
      endcase
   end

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // Poll timer
   // ----------------------------------------------------------------------
   always @* begin
      case (rate_code)
         2'b00:   poll_limit = POLL_CYC_RATE0;
         2'b01:   poll_limit = POLL_CYC_RATE1;
         2'b10:   poll_limit = POLL_CYC_RATE2;
         default: poll_limit = POLL_CYC_RATE3;
      endcase
   end

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         poll_cnt_q   <= 26'h0000000;
         poll_req_out <= 1'b0;
      end else if (poll_cnt_q >= poll_limit - 26'h0000001) begin
         poll_cnt_q   <= 26'h0000000;
         poll_req_out <= 1'b1;
      end else begin
         poll_cnt_q   <= poll_cnt_q + 26'h0000001;
         poll_req_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Retry and CPU write gating
   // ----------------------------------------------------------------------
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         retry_pend_q     <= 1'b0;
         retry_bit_out    <= 1'b0;
         cpu_write_go_out <= 1'b0;
      end else begin
         retry_pend_q     <= retry_pend_d;
         retry_bit_out    <= retry_pend_q &
                             ~config_three_q[`PFC_BIT_RETRY_SUPPRESS];
         cpu_write_go_out <= cpu_write_req_in &
                             config_three_q[`PFC_BIT_CPU_WRITE_PERMIT];
      end
   end

   // ----------------------------------------------------------------------
   // Automatic fan ramp
   // ----------------------------------------------------------------------
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         temp_q <= 8'h00;
      end else if (temp_valid_in) begin
         temp_q <= temp_in;
      end
   end

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         duty_out <= 24'h000000;
      end else begin
         duty_out <= ramp_duty;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pwm
         pfc_ramp u_ramp (
            .temp_in       (temp_q),
            .start_temp_in (start_temp_q),
            .span_code_in  (span_q[`PFC_SPAN_MSB:`PFC_SPAN_LSB]),
            .min_duty_in   (min_duty_in[gi*8 +: 8]),
            .max_duty_in   (max_duty_q[gi*8 +: 8]),
            .duty_out      (ramp_duty[gi*8 +: 8])
         );
      end
   endgenerate

endmodule

//--- src/pfc_consts.vh
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PFC_OFS_PECI_CONFIG_ONE   8'h36
`define PFC_OFS_PECI_CONFIG_THREE 8'h37
`define PFC_OFS_PWM1_MAX_DUTY     8'h38
`define PFC_OFS_PWM2_MAX_DUTY     8'h39
`define PFC_OFS_PWM3_MAX_DUTY     8'h3a
`define PFC_OFS_RAMP_START_TEMP   8'h3b
`define PFC_OFS_RAMP_SPAN         8'h3c

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define PFC_RST_CONFIG_ONE        8'h00
`define PFC_RST_CONFIG_THREE      8'h32
`define PFC_RST_MAX_DUTY          8'hff
`define PFC_RST_RAMP_START_TEMP   8'hd6
`define PFC_RST_RAMP_SPAN         8'hc0
`define PFC_MASK_CONFIG_ONE       8'h0f
`define PFC_MASK_CONFIG_THREE     8'hb3
`define PFC_MASK_RAMP_SPAN        8'hf0
`define PFC_READ_UNMAPPED         8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PFC_BIT_PROCESSOR_FOUND   0
`define PFC_BIT_RETRY_SUPPRESS    1
`define PFC_RATE_MSB              5
`define PFC_RATE_LSB              4
`define PFC_BIT_CPU_WRITE_PERMIT  7
`define PFC_SPAN_MSB              7
`define PFC_SPAN_LSB              4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFC_CLK_HZ                40000000
`define PFC_POLL_MS_RATE0         1000
`define PFC_POLL_MS_RATE1         500
`define PFC_POLL_MS_RATE2         200
`define PFC_POLL_MS_RATE3         100
`define PFC_MS_PER_S              1000
`define PFC_POLL_CYC_RATE0        26'd40000000
`define PFC_POLL_CYC_RATE1        26'd20000000
`define PFC_POLL_CYC_RATE2        26'd8000000
`define PFC_POLL_CYC_RATE3        26'd4000000
`define PFC_POLL_CNT_W            26

// ----------------------------------------------------------------------
// Ramp arithmetic
// ----------------------------------------------------------------------
`define PFC_DUTY_FULL             8'hff
`define PFC_DUTY_OFF              8'h00
`define PFC_FRAC_ONE              9'h100

`endif

//--- src/pfc_ramp.v
`timescale 1ns/1ps
`include "pfc_consts.vh"

module pfc_ramp (
   // Temperature and ramp settings
   input  wire [7:0] temp_in,
   input  wire [7:0] start_temp_in,
   input  wire [3:0] span_code_in,
   // Duty limits
   input  wire [7:0] min_duty_in,
   input  wire [7:0] max_duty_in,
   // Result
   output reg  [7:0] duty_out
);

   // ----------------------------------------------------------------------
   // Slope per degree: 2^24 / span rounded up, so exact ratios land on whole steps
   // ----------------------------------------------------------------------
   function [23:0] pfc_slope;
      input [3:0] code;
      begin
         case (code)
            4'h0:    pfc_slope = 24'h800000;
            4'h1:    pfc_slope = 24'h666667;
            4'h2:    pfc_slope = 24'h4ccccd;
            4'h3:    pfc_slope = 24'h400000;
            4'h4:    pfc_slope = 24'h333334;
            4'h5:    pfc_slope = 24'h266667;
            4'h6:    pfc_slope = 24'h200000;
            4'h7:    pfc_slope = 24'h19999a;
            4'h8:    pfc_slope = 24'h133334;
            4'h9:    pfc_slope = 24'h100000;
            4'ha:    pfc_slope = 24'h0ccccd;
            4'hb:    pfc_slope = 24'h09999a;
            4'hc:    pfc_slope = 24'h080000;
            4'hd:    pfc_slope = 24'h066667;
            4'he:    pfc_slope = 24'h04cccd;
            default: pfc_slope = 24'h033334;
         endcase
      end
   endfunction

   wire signed [8:0]  delta_s  = $signed({temp_in[7], temp_in}) -
                                 $signed({start_temp_in[7], start_temp_in});
   wire        [31:0] prod     = delta_s[7:0] * pfc_slope(span_code_in);
   wire               sat      = delta_s[8] | (|prod[31:24]) | (prod[23:16] == 8'hff);
   wire        [8:0]  frac     = sat ? `PFC_FRAC_ONE : {1'b0, prod[23:16]};
   wire        [7:0]  headroom = `PFC_DUTY_FULL - min_duty_in;
   wire        [16:0] step     = headroom * frac;
   wire        [8:0]  lin      = {1'b0, min_duty_in} + {1'b0, step[15:8]};
   wire               above    = ($signed(temp_in) > $signed(start_temp_in));

   reg         [7:0]  ramp;

   always @* begin
      ramp = `PFC_DUTY_OFF;
      if (above) begin
         if (frac[8] || lin[8]) begin
            ramp = `PFC_DUTY_FULL;
         end else begin
            ramp = lin[7:0];
         end
      end
      duty_out = (ramp > max_duty_in) ? max_duty_in : ramp;
   end

endmodule

//--- verification/pfc_top_chk.sv
`timescale 1ns/1ps
module pfc_top_chk (
   input wire        core_clk_in,
   input wire        resetn_in,
   input wire [7:0]  reg_addr_in,
   input wire        reg_wr_in,
   input wire [7:0]  reg_wdata_in,
   input wire        reg_rd_in,
   input wire [7:0]  reg_rdata_out,
   input wire        cpu_write_req_in,
   input wire        poll_req_out,
   input wire        retry_bit_out,
   input wire        cpu_write_go_out,
   input wire [23:0] duty_out
);
   // ----
   // Shadow of control and maximum duties
   // ----
   logic [7:0]  cfg_q;
   logic [23:0] mx_q;
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_q <= 8'h32;
         mx_q  <= 24'hffffff;
      end else if (reg_wr_in) begin
         if (reg_addr_in == 8'h37) cfg_q <= reg_wdata_in;
         if (reg_addr_in == 8'h38) mx_q[7:0] <= reg_wdata_in;
         if (reg_addr_in == 8'h39) mx_q[15:8] <= reg_wdata_in;
         if (reg_addr_in == 8'h3a) mx_q[23:16] <= reg_wdata_in;
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   // ----
   // Properties
   // ----
   write_gate_a: assert property (cpu_write_go_out == $past(cpu_write_req_in & cfg_q[7]))
      else $error("write go differs from gated request");
   retry_gate_a: assert property (retry_bit_out |-> !$past(cfg_q[1]))
      else $error("retry bit while suppressed");
   poll_pulse_a: assert property (poll_req_out |=> !poll_req_out)
      else $error("poll request longer than one cycle");
   unmapped_read_a: assert property (reg_rd_in && (reg_addr_in < 8'h36 || reg_addr_in > 8'h3c)
      |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   read_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without read");
   reserved_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h3c
      |=> reg_rdata_out[3:0] == 4'h0)
      else $error("span reserved bits not zero");
   cfg_read_a: assert property (reg_rd_in && reg_addr_in == 8'h37
      |=> reg_rdata_out[7:1] == ($past(cfg_q[7:1]) & 7'h59))
      else $error("control readback mismatch");
   duty_clamp_a: assert property (duty_out[7:0] <= $past(mx_q[7:0])
      && duty_out[15:8] <= $past(mx_q[15:8]) && duty_out[23:16] <= $past(mx_q[23:16]))
      else $error("duty above maximum");
   cover property (retry_bit_out);
   cover property (cpu_write_go_out);
   cover property (poll_req_out ##4 poll_req_out);
endmodule

//--- verification/pfc_peci_client.sv
`timescale 1ns/1ps
module pfc_peci_client (
   // Clock and poll request
   input  wire        core_clk_in,
   input  wire        poll_req_in,
   // Engine status towards the block
   output logic       detect_done_out,
   output logic       found_out,
   output logic       bad_out,
   output logic       good_out,
   output logic       wr_req_out,
   output logic       temp_valid_out,
   output logic [7:0] temp_out
);
   logic [7:0] temp_q = 8'h00;
   logic [1:0] poll_d = 2'b00;
   initial begin
      {detect_done_out, found_out, bad_out, good_out, wr_req_out, temp_valid_out} = 6'h0;
      temp_out = 8'h00;
   end
   // Answers each poll three cycles later; data toggles while not valid
   always @(posedge core_clk_in) begin
      poll_d <= {poll_d[0], poll_req_in};
      temp_valid_out <= poll_d[1];
      temp_out <= poll_d[1] ? temp_q : ~temp_out;
   end
   task automatic set_temp(input logic [7:0] t);
      temp_q = t;
   endtask
   // One-cycle detect result or completion code
   task automatic pulse(input logic det, input logic f, input logic bad);
      @(posedge core_clk_in);
      #1;
      found_out = f;
      detect_done_out = det;
      bad_out = !det && bad;
      good_out = !det && !bad;
      @(posedge core_clk_in);
      #1;
      {detect_done_out, bad_out, good_out} = 3'h0;
      found_out = !f;
   endtask
endmodule

//--- verification/peci_fan_control_config_tb_top.sv
`timescale 1ns/1ps
module peci_fan_control_config_tb_top;
   logic        core_clk_in, resetn_in, reg_wr_in, reg_rd_in, poll_req_out;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, temp_in;
   logic        detect_done_in, processor_found_in, bad_completion_in, good_completion_in;
   logic        cpu_write_req_in, temp_valid_in, retry_bit_out, cpu_write_go_out;
   logic [23:0] min_duty_in, duty_out;
   int          miscompares = 0;
   int          n_compared = 0;
   int          g;
   localparam int PR [4] = '{40, 20, 8, 4};
   logic [7:0]  rst_tab [7] = '{8'h00, 8'h32, 8'hff, 8'hff, 8'hff, 8'hd6, 8'hc0};
   logic [7:0]  msk_tab [7] = '{8'h0f, 8'hb3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0};
   logic [3:0]  spn [3] = '{4'h0, 4'hf, 4'hc};
   logic [7:0]  dt [3] = '{8'h01, 8'h28, 8'h10};

   pfc_top #(.POLL_CYC_RATE0(26'(PR[0])), .POLL_CYC_RATE1(26'(PR[1])),
      .POLL_CYC_RATE2(26'(PR[2])), .POLL_CYC_RATE3(26'(PR[3]))) uut (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .detect_done_in(detect_done_in),
      .processor_found_in(processor_found_in), .bad_completion_in(bad_completion_in),
      .good_completion_in(good_completion_in), .cpu_write_req_in(cpu_write_req_in),
      .temp_valid_in(temp_valid_in), .temp_in(temp_in), .poll_req_out(poll_req_out),
      .retry_bit_out(retry_bit_out), .cpu_write_go_out(cpu_write_go_out),
      .min_duty_in(min_duty_in), .duty_out(duty_out));
   pfc_peci_client peci (.core_clk_in(core_clk_in), .poll_req_in(poll_req_out),
      .detect_done_out(detect_done_in), .found_out(processor_found_in),
      .bad_out(bad_completion_in), .good_out(good_completion_in),
      .wr_req_out(cpu_write_req_in), .temp_valid_out(temp_valid_in), .temp_out(temp_in));

   initial begin
      core_clk_in = 0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   // ----
   // Access and compare tasks
   // ----
   task automatic stop_test();
      $display("Compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1;
      cyc(1);
      reg_wr_in = 0;
      cyc(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr_in = a;
      reg_rd_in = 1;
      cyc(1);
      reg_rd_in = 0;
      chk(24'(reg_rdata_out), 24'(e));
      cyc(1);
   endtask
   task automatic poll_gap(output int n);
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (poll_req_out !== 1'b1 && n < 100);
   endtask
   // ----
   // Tests
   // ----
   initial begin
      {resetn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      min_duty_in = 24'h412111;
      repeat (16) @(posedge core_clk_in);
      #1 resetn_in = 1;
      for (int i = 0; i < 7; i++) rd(8'h36 + 8'(i), rst_tab[i]);
      for (int i = 0; i < 7; i++) wr(8'h36 + 8'(i), 8'hff);
      for (int i = 0; i < 7; i++) rd(8'h36 + 8'(i), msk_tab[i]);
      wr(8'h40, 8'h5a);
      rd(8'h40, 8'h00);
      rd(8'h35, 8'h00);
      peci.pulse(0, 0, 1);
      cyc(3);
      chk(24'(retry_bit_out), 24'h0);
      wr(8'h37, 8'h30);
      cyc(3);
      chk(24'(retry_bit_out), 24'h1);
      peci.pulse(0, 0, 0);
      cyc(3);
      chk(24'(retry_bit_out), 24'h0);
      peci.wr_req_out = 1;
      cyc(2);
      chk(24'(cpu_write_go_out), 24'h0);
      wr(8'h37, 8'hb0);
      cyc(2);
      chk(24'(cpu_write_go_out), 24'h1);
      peci.wr_req_out = 0;
      peci.pulse(1, 1, 0);
      rd(8'h37, 8'hb1);
      peci.pulse(1, 0, 0);
      rd(8'h37, 8'hb0);
      for (int i = 0; i < 4; i++) begin
         wr(8'h37, 8'h80 | 8'(i << 4));
         repeat (3) poll_gap(g);
         chk(24'(g), 24'(PR[i]));
      end
      wr(8'h3b, 8'h10);
      for (int i = 0; i < 3; i++) begin
         wr(8'h3c, {spn[i], 4'h0});
         peci.set_temp(8'h10 + dt[i]);
         cyc(12);
         chk(duty_out, 24'ha09088);
      end
      peci.set_temp(8'h10);
      cyc(12);
      chk(duty_out, 24'h000000);
      wr(8'h38, 8'h80);
      peci.set_temp(8'h30);
      cyc(12);
      chk(duty_out, 24'hffff80);
      stop_test();
   end
   initial begin
      #(25 * 5000);
      miscompares++;
      stop_test();
   end
endmodule

bind pfc_top pfc_top_chk chk_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
   .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cpu_write_req_in(cpu_write_req_in),
   .poll_req_out(poll_req_out), .retry_bit_out(retry_bit_out),
   .cpu_write_go_out(cpu_write_go_out), .duty_out(duty_out));
